// ==== core/mss_regs.v ====
// Memory subsystem control and status registers with their decoded controls
`include "mss_defines.vh"
`default_nettype none

module mss_regs #(
  parameter HAS_L3 = 1,
  parameter HAS_ECC = 0
) (
  input wire CLK,
  input wire ARST_N,
  input wire HARD_RESET_N,
  input wire BUS_MODE_PIN_ZERO_N,
  input wire BUS_MODE_PIN_ONE_N,
  input wire [`SPR_NUM_W-1:0] SPR_NUM,
  input wire SPR_WE,
  input wire SPR_RE,
  input wire [0:31] SPR_WDATA,
  output reg [0:31] SPR_RDATA,
  output reg SPR_HIT,
  input wire L3_TICK,
  input wire L3_RD_ISSUE,
  input wire L3_WR_ISSUE,
  output wire L3_RD_ALLOW,
  output wire L3_WR_ALLOW,
  input wire L2_TAG_PERR,
  input wire L2_DATA_PERR,
  input wire L3_TAG_PERR,
  input wire L3_DATA_PERR,
  input wire ADDR_PERR,
  input wire DATA_PERR,
  input wire TRANSFER_ERR_ACK,
  input wire [6:0] REPORT_EN,
  output reg [6:0] ERR_DETECT_LOG,
  output reg [4:0] DTQ_LIMIT,
  output reg EXT_PUSH_MODE,
  output reg SPLIT_TXN_MODE,
  output reg [1:0] L2_PREFETCH_ENGINES,
  output reg [3:0] L3_TURNAROUND_CYCLES,
  output wire ADDR_BUS_DRIVEN,
  output wire PROCESSOR_INDEX,
  output wire [1:0] BUS_PROTOCOL
);

  // ==========================================================
  // Declarations
  reg [2:0] dtq_q;
  reg [2:0] dtq_d;
  reg intervention_disable_q;
  reg intervention_disable_d;
  reg tc_ext_q;
  reg tc_ext_d;
  reg tc_en_q;
  reg tc_en_d;
  reg [1:0] tc_q;
  reg [1:0] tc_d;
  reg [7:0] debug_q;
  reg [7:0] debug_d;
  reg [1:0] pfe_q;
  reg [1:0] pfe_d;
  reg [0:31] ctl_view;
  reg [0:31] sts_view;
  reg [4:0] dtq_limit_d;
  reg [3:0] turn_d;
  wire ctl_sel;
  wire sts_sel;
  wire ctl_wr;
  wire sts_wr;
  wire [6:0] err_event;
  wire [6:0] err_present;
  wire [6:0] err_set;
  wire [6:0] sts_q;
  wire turn_en;

  // ==========================================================
  // Register number decode
  assign ctl_sel = (SPR_NUM == `SPR_MSS_CONTROL);
  assign sts_sel = (SPR_NUM == `SPR_MSS_STATUS);
  assign ctl_wr = SPR_WE && ctl_sel;
  assign sts_wr = SPR_WE && sts_sel;

  // ==========================================================
  // Pin-derived read-only fields
  mode_pin_capture u_pins (
    .clk(CLK),
    .arst_n(ARST_N),
    .hard_reset_n(HARD_RESET_N),
    .mode_pin_zero_n(BUS_MODE_PIN_ZERO_N),
    .mode_pin_one_n(BUS_MODE_PIN_ONE_N),
    .bus_protocol_q(BUS_PROTOCOL),
    .addr_bus_driven_q(ADDR_BUS_DRIVEN),
    .proc_index_q(PROCESSOR_INDEX)
  );

  // ==========================================================
  // Writable control fields: next values from a register write
  always @* begin
    dtq_d = dtq_q;
    intervention_disable_d = intervention_disable_q;
    tc_ext_d = tc_ext_q;
    tc_en_d = tc_en_q;
    tc_d = tc_q;
    debug_d = debug_q;
    pfe_d = pfe_q;
    if (ctl_wr) begin
      dtq_d = SPR_WDATA[`CTL_DTQ_HI:`CTL_DTQ_LO];
      intervention_disable_d = SPR_WDATA[`CTL_INTERVENTION_DISABLE_BIT];
      // Without an L3 this bit is reserved and stays zero
      tc_ext_d = (HAS_L3 != 0) ? SPR_WDATA[`CTL_TC_EXT_BIT] : 1'b0;
      tc_en_d = SPR_WDATA[`CTL_TC_EN_BIT];
      tc_d = SPR_WDATA[`CTL_TC_HI:`CTL_TC_LO];
      // Debug bits are stored as written; nonzero is software's risk
      debug_d = SPR_WDATA[`CTL_DEBUG_HI:`CTL_DEBUG_LO];
      pfe_d = SPR_WDATA[`CTL_PFE_HI:`CTL_PFE_LO];
    end
  end

  // ==========================================================
  // Writable control fields: storage, cleared by either reset
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dtq_q <= 3'h0;
      intervention_disable_q <= 1'b0;
      tc_ext_q <= 1'b0;
      tc_en_q <= 1'b0;
      tc_q <= 2'h0;
      debug_q <= 8'h00;
      pfe_q <= 2'h0;
    end else if (!HARD_RESET_N) begin
      // Hard reset is a level on a pin, so it clears synchronously
      dtq_q <= 3'h0;
      intervention_disable_q <= 1'b0;
      tc_ext_q <= 1'b0;
      tc_en_q <= 1'b0;
      tc_q <= 2'h0;
      debug_q <= 8'h00;
      pfe_q <= 2'h0;
    end else begin
      dtq_q <= dtq_d;
      intervention_disable_q <= intervention_disable_d;
      tc_ext_q <= tc_ext_d;
      tc_en_q <= tc_en_d;
      tc_q <= tc_d;
      debug_q <= debug_d;
      pfe_q <= pfe_d;
    end
  end

  // ==========================================================
  // Control register read view, reserved bits forced to zero
  always @* begin
    ctl_view = `CTL_RESET;
    ctl_view[`CTL_DTQ_HI:`CTL_DTQ_LO] = dtq_q;
    ctl_view[`CTL_INTERVENTION_DISABLE_BIT] = intervention_disable_q;
    ctl_view[`CTL_TC_EXT_BIT] = tc_ext_q;
    ctl_view[`CTL_ABD_BIT] = ADDR_BUS_DRIVEN;
    ctl_view[`CTL_TC_EN_BIT] = tc_en_q;
    ctl_view[`CTL_TC_HI:`CTL_TC_LO] = tc_q;
    ctl_view[`CTL_BUS_PROTOCOL_SELECT_HI:`CTL_BUS_PROTOCOL_SELECT_LO] = BUS_PROTOCOL;
    ctl_view[`CTL_DEBUG_HI:`CTL_DEBUG_LO] = debug_q;
    ctl_view[`CTL_ID_BIT] = PROCESSOR_INDEX;
    // Bits 27 to 29 are never assigned and so read zero
    ctl_view[`CTL_PFE_HI:`CTL_PFE_LO] = pfe_q;
  end

  // ==========================================================
  // Queue depth and turnaround decode
  always @* begin
    case (dtq_q)
      `DTQ_ENC_8: dtq_limit_d = 5'h08;
      `DTQ_ENC_16: dtq_limit_d = 5'h10;
      // Code 011 is taken as three; the other codes are the depth itself
      default: dtq_limit_d = {2'h0, dtq_q};
    endcase
    if (tc_ext_q) begin
      turn_d = `TURN_EXT_CYC + {2'h0, tc_q};
    end else begin
      turn_d = `TURN_BASE_CYC + {2'h0, tc_q};
    end
  end

  // ==========================================================
  // Registered decoded controls toward the bus and cache logic
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DTQ_LIMIT <= 5'h08;
      EXT_PUSH_MODE <= 1'b0;
      SPLIT_TXN_MODE <= 1'b0;
      L2_PREFETCH_ENGINES <= 2'h0;
      L3_TURNAROUND_CYCLES <= 4'h0;
    end else begin
      DTQ_LIMIT <= dtq_limit_d;
      SPLIT_TXN_MODE <= (BUS_PROTOCOL == `BUS_PROTOCOL_SELECT_SPLIT);
      // Pushes replace interventions only on the split-transaction bus
      EXT_PUSH_MODE <= intervention_disable_q && (BUS_PROTOCOL == `BUS_PROTOCOL_SELECT_SPLIT);
      L2_PREFETCH_ENGINES <= pfe_q;
      L3_TURNAROUND_CYCLES <= tc_en_q ? turn_d : 4'h0;
    end
  end

  // ==========================================================
  // L3 read/write turnaround enforcement
  assign turn_en = tc_en_q;

  l3_turnaround_timer #(
    .CNT_W(4)
  ) u_turn (
    .clk(CLK),
    .arst_n(ARST_N),
    .l3_tick(L3_TICK),
    .gap_en(turn_en),
    .gap_cycles(turn_d),
    .rd_issue(L3_RD_ISSUE),
    .wr_issue(L3_WR_ISSUE),
    .rd_allow_q(L3_RD_ALLOW),
    .wr_allow_q(L3_WR_ALLOW)
  );

  // ==========================================================
  // Error events in status bit order 13 to 19
  assign err_event = {
    L2_TAG_PERR,
    L2_DATA_PERR,
    L3_TAG_PERR && (HAS_L3 != 0),
    L3_DATA_PERR && (HAS_L3 != 0),
    ADDR_PERR,
    DATA_PERR,
    TRANSFER_ERR_ACK
  };

  // Bits that exist on this variant; L3 bits vanish without an L3
  assign err_present = (HAS_L3 != 0) ? 7'h7F : 7'h67;

  // With ECC, reporting enables gate the status but not the detect log
  assign err_set = (HAS_ECC != 0) ? (err_event & REPORT_EN) : err_event;

  // ==========================================================
  // Sticky status bits; a new error beats a same-cycle software clear
  genvar gi;
  generate
    for (gi = 0; gi < `STS_NUM_BITS; gi = gi + 1) begin : g_sts
      reg bit_q;
      always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          bit_q <= 1'b0;
        end else if (!HARD_RESET_N) begin
          bit_q <= 1'b0;
        end else if (err_set[6-gi]) begin
          bit_q <= 1'b1;
        end else if (sts_wr) begin
          bit_q <= SPR_WDATA[`STS_FIRST_BIT+gi] && err_present[6-gi];
        end
      end
      assign sts_q[6-gi] = bit_q;
    end
  endgenerate

  // ==========================================================
  // Detect log keeps every error, whether reported or not
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ERR_DETECT_LOG <= 7'h00;
    end else if (!HARD_RESET_N) begin
      ERR_DETECT_LOG <= 7'h00;
    end else begin
      ERR_DETECT_LOG <= ERR_DETECT_LOG | err_event;
    end
  end

  // ==========================================================
  // Status register read view
  always @* begin
    sts_view = `STS_RESET;
    sts_view[`STS_FIRST_BIT:`STS_FIRST_BIT+`STS_NUM_BITS-1] = sts_q;
  end

  // ==========================================================
  // Read port: data and hit one cycle after the read strobe
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SPR_RDATA <= 32'h00000000;
      SPR_HIT <= 1'b0;
    end else if (SPR_RE && ctl_sel) begin
      SPR_RDATA <= ctl_view;
      SPR_HIT <= 1'b1;
    end else if (SPR_RE && sts_sel) begin
      SPR_RDATA <= sts_view;
      SPR_HIT <= 1'b1;
    end else begin
      // Unmapped numbers and idle cycles read as zero with no hit
      SPR_RDATA <= 32'h00000000;
      SPR_HIT <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== core/mss_defines.vh ====
// Constants for the memory subsystem control and status registers
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH

// ==========================================================
// Register numbers on the special-purpose register port
`define SPR_NUM_W 10
`define SPR_MSS_CONTROL 10'd1014
`define SPR_MSS_STATUS 10'd1015

// ==========================================================
// Control register fields, bit 0 is the most significant bit
`define CTL_DTQ_HI 3
`define CTL_DTQ_LO 5
`define CTL_INTERVENTION_DISABLE_BIT 7
`define CTL_TC_EXT_BIT 10
`define CTL_ABD_BIT 11
`define CTL_TC_EN_BIT 12
`define CTL_TC_HI 13
`define CTL_TC_LO 14
`define CTL_BUS_PROTOCOL_SELECT_HI 16
`define CTL_BUS_PROTOCOL_SELECT_LO 17
`define CTL_DEBUG_HI 18
`define CTL_DEBUG_LO 25
`define CTL_ID_BIT 26
`define CTL_PFE_HI 30
`define CTL_PFE_LO 31
`define CTL_RESET 32'h00000000

// ==========================================================
// Data transaction queue size encodings
`define DTQ_ENC_8 3'h0
`define DTQ_ENC_16 3'h1
`define DTQ_ENC_2 3'h2
`define DTQ_ENC_3 3'h3

// ==========================================================
// Bus protocol encodings
`define BUS_PROTOCOL_SELECT_BASE 2'h0
`define BUS_PROTOCOL_SELECT_SPLIT 2'h2

// ==========================================================
// Status register fields
`define STS_FIRST_BIT 13
`define STS_NUM_BITS 7
`define STS_L3_TAG_BIT 15
`define STS_L3_DATA_BIT 16
`define STS_RESET 32'h00000000

// ==========================================================
// L3 turnaround gap bases in L3 clock cycles
`define TURN_BASE_CYC 4'h2
`define TURN_EXT_CYC 4'h6

`endif

// ==== core/mode_pin_capture.v ====
// Capture of bus mode strap pins around hard reset
`default_nettype none

module mode_pin_capture (
  input wire clk,
  input wire arst_n,
  input wire hard_reset_n,
  input wire mode_pin_zero_n,
  input wire mode_pin_one_n,
  output reg [1:0] bus_protocol_q,
  output reg addr_bus_driven_q,
  output reg proc_index_q
);

  reg hard_reset_n_q;

  // ==========================================================
  // Sampling: protocol while hard reset holds, index and mode at release
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hard_reset_n_q <= 1'b0;
      bus_protocol_q <= 2'h0;
      addr_bus_driven_q <= 1'b0;
      proc_index_q <= 1'b0;
    end else begin
      hard_reset_n_q <= hard_reset_n;
      if (!hard_reset_n) begin
        bus_protocol_q <= {~mode_pin_zero_n, ~mode_pin_one_n};
      end
      // Pins are active low, so a driven-low pin reads as one
      if (hard_reset_n && !hard_reset_n_q) begin
        addr_bus_driven_q <= ~mode_pin_zero_n;
        proc_index_q <= ~mode_pin_one_n;
      end
    end
  end

endmodule
`default_nettype wire

// ==== core/l3_turnaround_timer.v ====
// Idle gap enforcement between L3 reads and writes
`default_nettype none

module l3_turnaround_timer #(
  parameter CNT_W = 4
) (
  input wire clk,
  input wire arst_n,
  input wire l3_tick,
  input wire gap_en,
  input wire [CNT_W-1:0] gap_cycles,
  input wire rd_issue,
  input wire wr_issue,
  output reg rd_allow_q,
  output reg wr_allow_q
);

  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg last_wr_q;
  reg last_wr_d;

  // ==========================================================
  // Each issue restarts the gap; the gap only blocks the other direction
  always @* begin
    cnt_d = cnt_q;
    last_wr_d = last_wr_q;
    if (rd_issue || wr_issue) begin
      cnt_d = gap_en ? gap_cycles : {CNT_W{1'b0}};
      last_wr_d = wr_issue;
    end else if (l3_tick && cnt_q != {CNT_W{1'b0}}) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // ==========================================================
  // Allows are registered from the next state so they line up with it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {CNT_W{1'b0}};
      last_wr_q <= 1'b0;
      rd_allow_q <= 1'b1;
      wr_allow_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      last_wr_q <= last_wr_d;
      rd_allow_q <= !(last_wr_d && cnt_d != {CNT_W{1'b0}});
      wr_allow_q <= !(!last_wr_d && cnt_d != {CNT_W{1'b0}});
    end
  end

endmodule
`default_nettype wire

// ==== dv/mss_regs_checker.sv ====
// Concurrent checks on the memory subsystem register block ports
`default_nettype none

module mss_regs_checker (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HARD_RESET_N,
  input wire logic BUS_MODE_PIN_ZERO_N,
  input wire logic BUS_MODE_PIN_ONE_N,
  input wire logic [9:0] SPR_NUM,
  input wire logic SPR_WE,
  input wire logic SPR_RE,
  input wire logic [0:31] SPR_WDATA,
  input wire logic [0:31] SPR_RDATA,
  input wire logic SPR_HIT,
  input wire logic L3_TICK,
  input wire logic L3_RD_ISSUE,
  input wire logic L3_WR_ISSUE,
  input wire logic L3_WR_ALLOW,
  input wire logic ADDR_PERR,
  input wire logic [6:0] ERR_DETECT_LOG,
  input wire logic [1:0] L2_PREFETCH_ENGINES,
  input wire logic [3:0] L3_TURNAROUND_CYCLES,
  input wire logic ADDR_BUS_DRIVEN,
  input wire logic PROCESSOR_INDEX,
  input wire logic [1:0] BUS_PROTOCOL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // ==========================================
  // Expected gap and prefetch fields of the word being written
  logic [3:0] turn_exp;
  logic [1:0] pfe_w;
  assign turn_exp = SPR_WDATA[12] ? (SPR_WDATA[10] ? 4'h6 : 4'h2) + {2'h0, SPR_WDATA[13:14]} : 4'h0;
  assign pfe_w = SPR_WDATA[30:31];

  // ==========================================
  // Steps: a control write followed by a quiet cycle, so outputs settle
  sequence s_ctl_wr;
    SPR_WE && SPR_NUM == 10'h3F6 && HARD_RESET_N ##1 !SPR_WE && HARD_RESET_N;
  endsequence
  sequence s_rd_gap2;
    L3_RD_ISSUE && !L3_WR_ISSUE && L3_TURNAROUND_CYCLES == 4'h2;
  endsequence
  sequence s_quiet;
    L3_TICK && !L3_RD_ISSUE && !L3_WR_ISSUE;
  endsequence

  // ==========================================
  // Register port, field decode, gap timing and pin capture
  a_ctl_read_hit: assert property (SPR_RE && SPR_NUM == 10'h3F6 |=> SPR_HIT)
    else $error("control read not answered");
  a_sts_read_hit: assert property (SPR_RE && SPR_NUM == 10'h3F7 |=> SPR_HIT && SPR_RDATA[20:31] == 12'h000)
    else $error("status read wrong");
  a_reserved_zero: assert property (SPR_HIT |-> SPR_RDATA[27:29] == 3'h0)
    else $error("reserved bits nonzero");
  a_prefetch_copy: assert property (s_ctl_wr |=> L2_PREFETCH_ENGINES == $past(pfe_w, 2))
    else $error("prefetch engines wrong");
  a_turn_select: assert property (s_ctl_wr |=> L3_TURNAROUND_CYCLES == $past(turn_exp, 2))
    else $error("turnaround count wrong");
  a_gap_hold: assert property (s_rd_gap2 |=> !L3_WR_ALLOW [*2])
    else $error("write allowed inside gap");
  a_gap_end: assert property (s_rd_gap2 ##1 s_quiet [*2] |=> L3_WR_ALLOW)
    else $error("gap too long");
  a_no_gap: assert property (L3_RD_ISSUE && !L3_WR_ISSUE && L3_TURNAROUND_CYCLES == 4'h0 |=> L3_WR_ALLOW)
    else $error("gap with turnaround off");
  a_proto_capture: assert property (!HARD_RESET_N |=> BUS_PROTOCOL == ~{$past(BUS_MODE_PIN_ZERO_N), $past(BUS_MODE_PIN_ONE_N)})
    else $error("bus protocol capture wrong");
  a_index_capture: assert property ($rose(HARD_RESET_N) |=> PROCESSOR_INDEX == !$past(BUS_MODE_PIN_ONE_N) && ADDR_BUS_DRIVEN == !$past(BUS_MODE_PIN_ZERO_N))
    else $error("index capture wrong");
  a_log_sticky: assert property (ADDR_PERR && HARD_RESET_N ##1 HARD_RESET_N |=> ERR_DETECT_LOG[2])
    else $error("address parity not logged");
endmodule

bind mss_regs mss_regs_checker chk_u (
  .CLK, .ARST_N, .HARD_RESET_N, .BUS_MODE_PIN_ZERO_N, .BUS_MODE_PIN_ONE_N, .SPR_NUM, .SPR_WE,
  .SPR_RE, .SPR_WDATA, .SPR_RDATA, .SPR_HIT, .L3_TICK, .L3_RD_ISSUE, .L3_WR_ISSUE, .L3_WR_ALLOW,
  .ADDR_PERR, .ERR_DETECT_LOG, .L2_PREFETCH_ENGINES, .L3_TURNAROUND_CYCLES, .ADDR_BUS_DRIVEN,
  .PROCESSOR_INDEX, .BUS_PROTOCOL
);

`default_nettype wire

// ==== dv/l3_agent.sv ====
// Far-side model: L3 issuer and its SRAM clock ticks
`default_nettype none

module l3_agent (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rd_go,
  input wire logic wr_go,
  input wire logic rd_allow,
  input wire logic wr_allow,
  output logic tick,
  output logic rd_issue,
  output logic wr_issue
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // One SRAM clock per core clock keeps gap counts short and exact;
  // an access starts only while the block allows it, one pulse per request
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick <= 1'b0;
      rd_issue <= 1'b0;
      wr_issue <= 1'b0;
    end else begin
      tick <= 1'b1;
      rd_issue <= rd_go && rd_allow && !rd_issue;
      wr_issue <= wr_go && wr_allow && !wr_issue;
    end
  end
endmodule

`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the memory subsystem register block
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hrst_n = 1'b0;
  logic pin0_n = 1'b0;
  logic pin1_n = 1'b1;
  logic [9:0] spr_num = 10'h000;
  logic spr_we = 1'b0;
  logic spr_re = 1'b0;
  logic [31:0] spr_wdata = 32'h00000000;
  logic [6:0] ev = 7'h00;
  logic rd_go = 1'b0;
  logic wr_go = 1'b0;
  logic [31:0] spr_rdata;
  logic [31:0] wd;
  logic spr_hit, tick, rd_issue, wr_issue, rd_allow, wr_allow;
  logic ext_push, split, abd, pidx;
  logic [6:0] log_q;
  logic [4:0] data_txn_queue_size;
  logic [1:0] pfe, proto;
  logic [3:0] turn;
  int dtq_tab[8] = '{8, 16, 2, 3, 4, 5, 6, 7};
  int err_count = 0;
  int tests_run = 0;
  int i;
  int n;

  always #12.5 clk = ~clk;

  mss_regs dut_u (
    .CLK(clk), .ARST_N(arst_n), .HARD_RESET_N(hrst_n),
    .BUS_MODE_PIN_ZERO_N(pin0_n), .BUS_MODE_PIN_ONE_N(pin1_n),
    .SPR_NUM(spr_num), .SPR_WE(spr_we), .SPR_RE(spr_re), .SPR_WDATA(spr_wdata),
    .SPR_RDATA(spr_rdata), .SPR_HIT(spr_hit), .L3_TICK(tick),
    .L3_RD_ISSUE(rd_issue), .L3_WR_ISSUE(wr_issue), .L3_RD_ALLOW(rd_allow),
    .L3_WR_ALLOW(wr_allow), .L2_TAG_PERR(ev[6]), .L2_DATA_PERR(ev[5]),
    .L3_TAG_PERR(ev[4]), .L3_DATA_PERR(ev[3]), .ADDR_PERR(ev[2]), .DATA_PERR(ev[1]),
    .TRANSFER_ERR_ACK(ev[0]), .REPORT_EN(7'h00), .ERR_DETECT_LOG(log_q),
    .DTQ_LIMIT(data_txn_queue_size), .EXT_PUSH_MODE(ext_push), .SPLIT_TXN_MODE(split),
    .L2_PREFETCH_ENGINES(pfe), .L3_TURNAROUND_CYCLES(turn),
    .ADDR_BUS_DRIVEN(abd), .PROCESSOR_INDEX(pidx), .BUS_PROTOCOL(proto)
  );

  l3_agent far_u (
    .clk(clk), .arst_n(arst_n), .rd_go(rd_go), .wr_go(wr_go), .rd_allow(rd_allow),
    .wr_allow(wr_allow), .tick(tick), .rd_issue(rd_issue), .wr_issue(wr_issue)
  );

  // ==========================================
  // Helpers; every access leaves a quiet cycle so strobes never retoggle in one step
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic spr_wr(input logic [9:0] num, input logic [31:0] d);
    spr_num = num;
    spr_wdata = d;
    spr_we = 1'b1;
    cyc(1);
    spr_we = 1'b0;
    cyc(1);
  endtask

  task automatic spr_rd(input logic [9:0] num, input logic hit, input logic [31:0] exp);
    spr_num = num;
    spr_re = 1'b1;
    cyc(1);
    spr_re = 1'b0;
    chk(32'(spr_hit), 32'(hit));
    chk(spr_rdata, exp);
    cyc(1);
  endtask

  task automatic issue(input logic rd);
    rd_go = rd;
    wr_go = !rd;
    cyc(1);
    rd_go = 1'b0;
    wr_go = 1'b0;
    cyc(1);
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    cyc(3);
    arst_n = 1'b1;
    cyc(2);
    hrst_n = 1'b1;
    cyc(2);
    chk(32'(proto), 32'h2);
    chk(32'({split, abd, pidx}), 32'h6);
    chk(32'(data_txn_queue_size), 32'h8);
    spr_rd(10'd1014, 1'b1, 32'h00108000);
    spr_rd(10'd1015, 1'b1, 32'h00000000);
    spr_rd(10'd1013, 1'b0, 32'h00000000);
    // Each queue code, with the ID bit and reserved bits 27 to 29 written high
    for (i = 0; i < 8; i++) begin
      wd = (32'(i) << 26) | 32'h0100003C | 32'(i[1:0]);
      spr_wr(10'd1014, wd);
      cyc(1);
      chk(32'(data_txn_queue_size), 32'(dtq_tab[i]));
      chk(32'({ext_push, pfe}), 32'(4 + i[1:0]));
      spr_rd(10'd1014, 1'b1, (wd & 32'hFFFFFFC3) | 32'h00108000);
    end
    for (i = 0; i < 8; i++) begin
      spr_wr(10'd1014, 32'h00080000 | (32'(i[2]) << 21) | (32'(i[1:0]) << 17));
      cyc(1);
      chk(32'(turn), 32'(i[2] ? 6 + i[1:0] : 2 + i[1:0]));
    end
    // Gap of two SRAM clocks after a read, then no gap at all
    spr_wr(10'd1014, 32'h00080000);
    issue(1'b1);
    for (n = 1; n < 20 && !wr_allow; n++) cyc(1);
    chk(32'(n), 32'd3);
    if (n == 20) conclude();
    spr_wr(10'd1014, 32'h00000000);
    cyc(1);
    issue(1'b0);
    chk(32'({rd_allow, turn}), 32'h10);
    issue(1'b1);
    chk(32'(wr_allow), 32'h1);
    // Every error source in turn; bits accumulate
    for (i = 0; i < 7; i++) begin
      ev = 7'(1 << i);
      cyc(1);
      ev = 7'h00;
      spr_rd(10'd1015, 1'b1, 32'((2 << i) - 1) << 12);
    end
    chk(32'(log_q), 32'h7F);
    // A clear that meets a new event loses to it
    ev = 7'h01;
    spr_wr(10'd1015, 32'h00000000);
    ev = 7'h00;
    spr_rd(10'd1015, 1'b1, 32'h00001000);
    spr_wr(10'd1015, 32'h00000000);
    spr_rd(10'd1015, 1'b1, 32'h00000000);
    chk(32'(log_q), 32'h7F);
    // Second hard reset with the mode pins swapped
    pin0_n = 1'b1;
    pin1_n = 1'b0;
    hrst_n = 1'b0;
    cyc(2);
    hrst_n = 1'b1;
    cyc(2);
    chk(32'({split, abd, pidx, proto}), 32'h5);
    chk(32'({log_q, data_txn_queue_size}), 32'h8);
    spr_rd(10'd1015, 1'b1, 32'h00000000);
    spr_wr(10'd1014, 32'h01000000);
    spr_wr(10'd1013, 32'hFFFFFFFF);
    cyc(1);
    chk(32'(ext_push), 32'h0);
    spr_rd(10'd1014, 1'b1, 32'h01004020);
    conclude();
  end
endmodule

`default_nettype wire
